/* core/eef_bus_front.sv */
`default_nettype none

module eef_bus_front (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic samp_clk,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  input  wire logic tx_drive_low,
  output logic      start_pulse,
  output logic      stop_pulse,
  output logic      bit_pulse,
  output logic      bit_value,
  output logic      bus_idle,
  output logic      bus_active
);

  // ----------------------------------------------------------------
  // Sampling domain reset and pin synchronisers
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_s_q;
  logic scl_meta_q;
  logic scl_sync_q;
  logic sda_meta_q;
  logic sda_sync_q;
  logic drv_meta_q;
  logic drv_sync_q;

  always_ff @(posedge samp_clk) begin
    rst_meta_q <= sys_rst;
    rst_s_q    <= rst_meta_q;
  end

  always_ff @(posedge samp_clk) begin
    scl_meta_q <= scl_i;
    scl_sync_q <= scl_meta_q;
    sda_meta_q <= sda_i;
    sda_sync_q <= sda_meta_q;
  end

  always_ff @(posedge samp_clk) begin
    drv_meta_q <= tx_drive_low;
    drv_sync_q <= drv_meta_q;
  end

  // ----------------------------------------------------------------
  // Spike filters and edge detection
  // ----------------------------------------------------------------
  logic scl_f;
  logic sda_f;
  logic scl_prev_q;
  logic sda_prev_q;

  eef_glitch_filter #(
    .FILT_CYC (eef_pkg::FILT_CYC),
    .FILT_W   (eef_pkg::FILT_W)
  ) u_scl_filt (
    .clk   (samp_clk),
    .rst   (rst_s_q),
    .raw   (scl_sync_q),
    .level (scl_f)
  );

  eef_glitch_filter #(
    .FILT_CYC (eef_pkg::FILT_CYC),
    .FILT_W   (eef_pkg::FILT_W)
  ) u_sda_filt (
    .clk   (samp_clk),
    .rst   (rst_s_q),
    .raw   (sda_sync_q),
    .level (sda_f)
  );

  always_ff @(posedge samp_clk) begin
    if (rst_s_q) begin
      scl_prev_q <= eef_pkg::LINE_RST;
      sda_prev_q <= eef_pkg::LINE_RST;
    end else begin
      scl_prev_q <= scl_f;
      sda_prev_q <= sda_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic idle_now;

  assign scl_rise  = scl_f & ~scl_prev_q;
  assign scl_fall  = ~scl_f & scl_prev_q;
  // Clock held high across the data edge: condition, not data
  assign start_det = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
  assign stop_det  = scl_f & scl_prev_q & ~sda_prev_q & sda_f;
  assign idle_now  = scl_f & sda_f;

  // ----------------------------------------------------------------
  // Bus state
  // ----------------------------------------------------------------
  eef_pkg::eef_state_type state_q;

  always_ff @(posedge samp_clk) begin
    if (rst_s_q) begin
      state_q <= eef_pkg::EEF_IDLE;
    end else begin
      case (state_q)
        eef_pkg::EEF_IDLE: begin
          if (start_det) begin
            state_q <= eef_pkg::EEF_ACTIVE;
          end
        end
        eef_pkg::EEF_ACTIVE: begin
          if (stop_det) begin
            state_q <= eef_pkg::EEF_IDLE;
          end
        end
        default: begin
          state_q <= eef_pkg::EEF_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Received bits: one per clock rise while active
  // ----------------------------------------------------------------
  logic bit_tgl_q;
  logic bit_val_s_q;
  logic start_tgl_q;
  logic stop_tgl_q;
  logic idle_s_q;
  logic act_s_q;

  always_ff @(posedge samp_clk) begin
    if (rst_s_q) begin
      bit_tgl_q   <= 1'b0;
      bit_val_s_q <= 1'b0;
    end else if (scl_rise && state_q == eef_pkg::EEF_ACTIVE) begin
      bit_tgl_q   <= ~bit_tgl_q;
      bit_val_s_q <= sda_f;
    end
  end

  always_ff @(posedge samp_clk) begin
    if (rst_s_q) begin
      start_tgl_q <= 1'b0;
      stop_tgl_q  <= 1'b0;
    end else begin
      if (start_det) begin
        start_tgl_q <= ~start_tgl_q;
      end
      if (stop_det) begin
        stop_tgl_q <= ~stop_tgl_q;
      end
    end
  end

  always_ff @(posedge samp_clk) begin
    if (rst_s_q) begin
      idle_s_q <= 1'b1;
      act_s_q  <= 1'b0;
    end else begin
      idle_s_q <= idle_now;
      act_s_q  <= (state_q == eef_pkg::EEF_ACTIVE);
    end
  end

  // ----------------------------------------------------------------
  // Transmit: open-drain, changed only late in clock low
  // ----------------------------------------------------------------
  logic [eef_pkg::HOLD_W-1:0] hold_q;
  logic                       oe_q;

  always_ff @(posedge samp_clk) begin
    if (rst_s_q || scl_f) begin
      hold_q <= '0;
    end else if (scl_fall) begin
      hold_q <= eef_pkg::HOLD_W'(eef_pkg::HOLD_CYC);
    end else if (hold_q != '0) begin
      hold_q <= hold_q - eef_pkg::HOLD_W'(1);
    end
  end

  always_ff @(posedge samp_clk) begin
    if (rst_s_q || state_q == eef_pkg::EEF_IDLE || stop_det) begin
      oe_q <= 1'b0;
    end else if (!scl_f && !scl_fall && hold_q == '0) begin
      oe_q <= drv_sync_q;
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = oe_q;

  // ----------------------------------------------------------------
  // Crossing to the system clock
  // ----------------------------------------------------------------
  logic [2:0] bit_sy_q;
  logic [2:0] start_sy_q;
  logic [2:0] stop_sy_q;
  logic [1:0] idle_sy_q;
  logic [1:0] act_sy_q;
  logic       start_p_q;
  logic       stop_p_q;
  logic       bit_p_q;
  logic       bit_v_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bit_sy_q   <= 3'h0;
      start_sy_q <= 3'h0;
      stop_sy_q  <= 3'h0;
      idle_sy_q  <= 2'h3;
      act_sy_q   <= 2'h0;
    end else begin
      bit_sy_q   <= {bit_sy_q[1:0], bit_tgl_q};
      start_sy_q <= {start_sy_q[1:0], start_tgl_q};
      stop_sy_q  <= {stop_sy_q[1:0], stop_tgl_q};
      idle_sy_q  <= {idle_sy_q[0], idle_s_q};
      act_sy_q   <= {act_sy_q[0], act_s_q};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      start_p_q <= 1'b0;
      stop_p_q  <= 1'b0;
      bit_p_q   <= 1'b0;
    end else begin
      start_p_q <= start_sy_q[2] ^ start_sy_q[1];
      stop_p_q  <= stop_sy_q[2] ^ stop_sy_q[1];
      bit_p_q   <= bit_sy_q[2] ^ bit_sy_q[1];
    end
  end

  // Bit value settles with its toggle and is taken three edges later
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bit_v_q <= 1'b0;
    end else if (bit_sy_q[2] ^ bit_sy_q[1]) begin
      bit_v_q <= bit_val_s_q;
    end
  end

  assign start_pulse = start_p_q;
  assign stop_pulse  = stop_p_q;
  assign bit_pulse   = bit_p_q;
  assign bit_value   = bit_v_q;
  assign bus_idle    = idle_sy_q[1];
  assign bus_active  = act_sy_q[1];

endmodule : eef_bus_front

`default_nettype wire

/* core/eef_glitch_filter.sv */
`default_nettype none

module eef_glitch_filter #(
  parameter int FILT_CYC = eef_pkg::FILT_CYC,
  parameter int FILT_W   = eef_pkg::FILT_W
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic raw,
  output logic      level
);

  logic [FILT_W-1:0] cnt_q;
  logic              level_q;

  // ----------------------------------------------------------------
  // Accept a new level only after it holds FILT_CYC+1 samples
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (raw == level_q) begin
      cnt_q <= '0;
    end else if (cnt_q != FILT_W'(FILT_CYC)) begin
      cnt_q <= cnt_q + FILT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level_q <= eef_pkg::LINE_RST;
    end else if (raw != level_q && cnt_q == FILT_W'(FILT_CYC)) begin
      level_q <= raw;
    end
  end

  assign level = level_q;

endmodule : eef_glitch_filter

`default_nettype wire

/* core/eef_pkg.sv */
// Summary of operation
// - Master picks direction; device follows user request
// - Clock pin is input only, never driven
// - Data pin only pulled low or released
// - Data changes only while clock is low
// - Data change during clock high is condition
// - Bus idle when clock and data high
// - Hold output 300 ns after clock fall
// - Reject spikes up to 50 ns on inputs
// - Start is data fall during clock high
// - Stop is data rise during clock high
// - One bit per clock pulse, sampled high
`default_nettype none

package eef_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SAMP_PERIOD_NS = 30;
  localparam int SPIKE_NS       = 50;
  localparam int TX_HOLD_NS     = 300;

  // Spike longest time: input must differ this many extra samples
  localparam int FILT_CYC = (SPIKE_NS + SAMP_PERIOD_NS - 1) / SAMP_PERIOD_NS;
  // Least hold time after clock fall, rounded up
  localparam int HOLD_CYC = (TX_HOLD_NS + SAMP_PERIOD_NS - 1) / SAMP_PERIOD_NS;

  localparam int FILT_W = $clog2(FILT_CYC + 1);
  localparam int HOLD_W = $clog2(HOLD_CYC + 1);

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic LINE_RST = 1'b1;

  typedef enum logic [0:0] {
    EEF_IDLE,
    EEF_ACTIVE
  } eef_state_type;

endpackage : eef_pkg

`default_nettype wire

/* testbench/eef_bus_front_checker.sv */
`default_nettype none
module eef_bus_front_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic samp_clk,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic start_pulse,
  input wire logic stop_pulse,
  input wire logic bit_pulse,
  input wire logic bus_idle,
  input wire logic bus_active
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] low_q;
  // Samples that the clock pin has been low
  always_ff @(posedge samp_clk) begin
    if (sys_rst || scl_i) low_q <= 8'h00;
    else if (low_q != 8'hFF) low_q <= low_q + 8'h01;
  end
  sequence s_up; !start_pulse ##[0:5] bus_active; endsequence
  sequence s_down; !stop_pulse ##[0:5] !bus_active; endsequence
  property p_drain; @(posedge clk) disable iff (sys_rst) sda_o == 1'b0; endproperty
  a_drain: assert property (p_drain) else $error("data driven high");
  property p_start; @(posedge clk) disable iff (sys_rst) start_pulse |=> s_up; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_stop; @(posedge clk) disable iff (sys_rst) stop_pulse |=> s_down; endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");
  property p_bit; @(posedge clk) disable iff (sys_rst) bit_pulse |-> bus_active && !start_pulse && !stop_pulse;
  endproperty
  a_bit: assert property (p_bit) else $error("bit outside transfer");
  property p_hold; @(posedge samp_clk) disable iff (sys_rst) $changed(sda_oe) |-> low_q >= 8'h0C; endproperty
  a_hold: assert property (p_hold) else $error("data line changed too early");
  property p_idle; @(posedge samp_clk) disable iff (sys_rst) low_q >= 8'h0C |-> !bus_idle; endproperty
  a_idle: assert property (p_idle) else $error("idle with clock low");
  property p_busy; @(posedge clk) disable iff (sys_rst) $rose(bus_active) |-> ##[0:4] !bus_idle; endproperty
  a_busy: assert property (p_busy) else $error("idle after start");
  property p_rel; @(posedge clk) disable iff (sys_rst) stop_pulse |-> sda_oe == 1'b0; endproperty
  a_rel: assert property (p_rel) else $error("data held at stop");
endmodule : eef_bus_front_checker
bind eef_bus_front eef_bus_front_checker eef_bus_front_checker_i (.clk(clk), .sys_rst(sys_rst),
  .samp_clk(samp_clk), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe), .start_pulse(start_pulse),
  .stop_pulse(stop_pulse), .bit_pulse(bit_pulse), .bus_idle(bus_idle), .bus_active(bus_active));
`default_nettype wire

/* testbench/eef_bus_front_test.sv */
`default_nettype none
module eef_bus_front_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic samp_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic tx_drive_low = 1'b0;
  logic scl_i, sda_i, sda_o, sda_oe, start_pulse, stop_pulse, bit_pulse, bit_value, bus_idle, bus_active, seen;
  int err_total = 0;
  int samples_checked = 0;
  int n_start, n_stop, n_bit;
  // Rows: data sent, device pulls low, expected line
  logic [2:0] rows [5] = '{3'b101, 3'b000, 3'b110, 3'b010, 3'b101};
`define EEF_CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
  initial forever #10 clk = ~clk;
  initial begin
    #7;
    forever #15 samp_clk = ~samp_clk;
  end
  eef_bus_front eef_bus_front_i (.clk(clk), .sys_rst(sys_rst), .samp_clk(samp_clk), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .tx_drive_low(tx_drive_low), .start_pulse(start_pulse), .stop_pulse(stop_pulse),
    .bit_pulse(bit_pulse), .bit_value(bit_value), .bus_idle(bus_idle), .bus_active(bus_active));
  eef_bus_master eef_bus_master_i (.clk(clk), .sda_o(sda_o), .sda_oe(sda_oe), .scl_i(scl_i), .sda_i(sda_i));
  always @(posedge clk) begin
    if (sys_rst) begin
      n_start <= 0;
      n_stop <= 0;
      n_bit <= 0;
    end else begin
      n_start <= n_start + int'(start_pulse === 1'b1);
      n_stop <= n_stop + int'(stop_pulse === 1'b1);
      n_bit <= n_bit + int'(bit_pulse === 1'b1);
    end
  end
  task summarize;
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (50000) @(posedge clk);
    err_total++;
    summarize;
  end
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clk);
    `EEF_CHK("idle", 1'b1, bus_idle)
    `EEF_CHK("active", 1'b0, bus_active)
    `EEF_CHK("oe", 1'b0, sda_oe)
    tx_drive_low <= 1'b1;
    eef_bus_master_i.bit_cyc(1'b0, seen);
    eef_bus_master_i.bit_cyc(1'b1, seen);
    `EEF_CHK("idle line", 1'b1, seen)
    `EEF_CHK("idle bits", 0, n_bit)
    tx_drive_low <= 1'b0;
    eef_bus_master_i.start;
    `EEF_CHK("starts", 1, n_start)
    for (int i = 0; i < 5; i++) begin
      tx_drive_low <= rows[i][1];
      repeat (5) @(posedge clk);
      eef_bus_master_i.bit_cyc(rows[i][2], seen);
      `EEF_CHK("bit", rows[i][0], bit_value)
      `EEF_CHK("line", rows[i][0], seen)
    end
    `EEF_CHK("bits", 5, n_bit)
    eef_bus_master_i.spike;
    `EEF_CHK("spike starts", 1, n_start)
    `EEF_CHK("spike stops", 0, n_stop)
    eef_bus_master_i.clk_spike;
    `EEF_CHK("spike bits", 5, n_bit)
    eef_bus_master_i.start;
    `EEF_CHK("restart", 2, n_start)
    `EEF_CHK("still active", 1'b1, bus_active)
    eef_bus_master_i.stop;
    `EEF_CHK("stops", 1, n_stop)
    `EEF_CHK("released", 1'b0, bus_active)
    `EEF_CHK("idle again", 1'b1, bus_idle)
    `EEF_CHK("oe off", 1'b0, sda_oe)
    eef_bus_master_i.start;
    eef_bus_master_i.bit_cyc(1'b1, seen);
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clk);
    `EEF_CHK("rst active", 1'b0, bus_active)
    `EEF_CHK("rst idle", 1'b1, bus_idle)
    eef_bus_master_i.stop;
    `EEF_CHK("rst stops", 1, n_stop)
    `EEF_CHK("rst bits", 0, n_bit)
    summarize;
  end
endmodule : eef_bus_front_test
`default_nettype wire

/* testbench/eef_bus_master.sv */
`default_nettype none
module eef_bus_master (
  input  wire logic clk,
  input  wire logic sda_o,
  input  wire logic sda_oe,
  output logic      scl_i,
  output logic      sda_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic scl_q = 1'b1;
  logic low_q = 1'b0;
  assign scl_i = scl_q;
  // Pull-up unless either party pulls low
  assign sda_i = !(low_q || (sda_oe && !sda_o));
  task step(input logic c, input logic d, input int n);
    @(posedge clk);
    scl_q <= c;
    low_q <= !d;
    repeat (n - 1) @(posedge clk);
  endtask : step
  task start;
    step(1'b0, !low_q, 20);
    step(1'b0, 1'b1, 20);
    step(1'b1, 1'b1, 20);
    step(1'b1, 1'b0, 20);
  endtask : start
  task stop;
    step(1'b0, !low_q, 20);
    step(1'b0, 1'b0, 20);
    step(1'b1, 1'b0, 20);
    step(1'b1, 1'b1, 20);
  endtask : stop
  task bit_cyc(input logic d, output logic seen);
    step(1'b0, !low_q, 20);
    step(1'b0, d, 20);
    step(1'b1, d, 10);
    seen = sda_i;
    step(1'b1, d, 10);
  endtask : bit_cyc
  // 40 ns data pulse while clock is high
  task spike;
    step(1'b1, low_q, 2);
    step(1'b1, low_q, 20);
  endtask : spike
  // 40 ns clock dip while the clock is high
  task clk_spike;
    step(1'b0, !low_q, 2);
    step(1'b1, !low_q, 20);
  endtask : clk_spike
endmodule : eef_bus_master
`default_nettype wire
